// ---- bench/mrrc_checker.sv ----
// Port assertions for the management routing block
`timescale 1ns/1ps
`default_nettype none
module mrrc_checker (
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic                  pcie_fundamental_reset_pin,
    input wire logic                  pcie_inband_reset,
    input wire logic                  power_saving,
    input wire logic                  wake_arp_in,
    input wire mrrc_pkg::mrrc_pkt_s   pkt_in,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic                  avs_waitrequest,
    input wire logic                  phy_reset,
    input wire logic                  phy_power_keep,
    input wire logic                  phy_hold_power_state,
    input wire logic                  wake_arp_out,
    input wire mrrc_pkg::mrrc_route_s route_out
);
    import mrrc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence taken_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    bus_answer_a: assert property (taken_s |=> !avs_waitrequest)
        else $error("request not answered");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    phy_reset_a: assert property ($stable(phy_hold_power_state) |-> phy_reset ==
        ($past(pcie_fundamental_reset_pin | pcie_inband_reset) && !phy_hold_power_state))
        else $error("phy reset wrong");
    power_keep_a: assert property (phy_power_keep |-> $past(power_saving))
        else $error("phy kept powered outside power saving");
    wake_arp_a: assert property (wake_arp_out == $past(wake_arp_in))
        else $error("wake match altered");
    host_route_a: assert property (route_out.to_host |->
        route_out.to_mgmt && $past(|pkt_in.filter_hit)) else $error("bad host route");
    no_packet_a: assert property (!$past(pkt_in.valid) |-> !route_out.to_mgmt)
        else $error("route without packet");
    bcast_block_a: assert property ($past(pkt_in.broadcast && !pkt_in.l2_pass)
        |-> !route_out.to_mgmt) else $error("broadcast forwarded");
endmodule
bind mrrc_top mrrc_checker chk (.*);
`default_nettype wire

// ---- bench/mrrc_mc_model.sv ----
// Management controller model: bus master for the control registers
`timescale 1ns/1ps
`default_nettype none
module mrrc_mc_model (
    input  wire logic       mclk,
    input  wire logic       avs_waitrequest,
    output var logic [15:0] avs_address,
    output var logic        avs_read,
    output var logic        avs_write,
    output var logic [31:0] avs_writedata
);
    initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
    // Only this controller writes the control register, one request at a time
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the management routing block
`timescale 1ns/1ps
`default_nettype none
`include "mrrc_regs.svh"
`define CHK(n, x, y) begin checks++; if ((y) !== (x)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, x, y); end end
module tb;
    import mrrc_pkg::*;
    logic        mclk, rst_n, mgmt_reset_event, nvm_skip_phy_reset, pcie_fundamental_reset_pin;
    logic        pcie_inband_reset, power_saving, wake_arp_in, avs_read, avs_write, sent, sent_d;
    logic        avs_waitrequest, phy_reset, phy_power_keep, phy_hold_power_state, wake_arp_out;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, w, c, e;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [1:0]  avs_response, er;
    logic [2:0]  ep;
    logic [7:0]  rnd = 8'h2c, rt;
    mrrc_route_s route_out;
    mrrc_pkt_s   pkt_in, pv;
    logic [31:0] qd[$];
    logic [2:0]  qp[$];
    logic [1:0]  qr[$];
    int          err_total, checks, cyc;
    mrrc_top DUT (.*);
    mrrc_mc_model mc (.*);
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [2:0] model(input mrrc_pkt_s p, input logic [31:0] c, input logic [7:0] r);
        logic m;
        logic l;
        l = p.l2_pass | (c[20] & p.multicast & ~p.broadcast);
        m = p.valid & c[17] & l
            & (~c[23] | p.xsum_ok) & (~c[25] | (p.vlan_tagged == c[26]))
            & (c[28] | ~p.is_arp_req | (p.ip_filter_cfg & |p.ip_match))
            & (c[19] | |p.filter_hit);
        return {m, m & c[21] & |(p.filter_hit & r), l};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        qd.push_back(x);
        qr.push_back((a == `MRRC_OFS_CTRL || a == `MRRC_OFS_ROUTE || a == `MRRC_OFS_AUX) ?
                     2'b00 : 2'b10);
        mc.xfer(1'b0, a, '0);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
        if (rst_n) begin
            rnd <= lfsr(rnd);
            {pcie_fundamental_reset_pin, pcie_inband_reset, power_saving, wake_arp_in} <= rnd[3:0];
        end
        sent_d <= sent;
        if (avs_read && !avs_waitrequest) begin
            e = qd.pop_front();
            `CHK("readdata", e, avs_readdata)
            er = qr.pop_front();
            `CHK("response", er, avs_response)
        end
        if (sent_d) begin
            ep = qp.pop_front();
            `CHK("route", ep, {route_out.to_mgmt, route_out.to_host, route_out.mcst_l2})
        end
    end
    initial begin
        {rst_n, mgmt_reset_event, nvm_skip_phy_reset, sent, sent_d, pkt_in} = '0;
        {pcie_fundamental_reset_pin, pcie_inband_reset, power_saving, wake_arp_in} = '0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(`MRRC_OFS_CTRL, 32'h10000000);
        rd(`MRRC_OFS_ROUTE, 32'h0);
        mc.xfer(1'b1, `MRRC_OFS_CTRL, '1);
        rd(`MRRC_OFS_CTRL, 32'h16ba0000);
        nvm_skip_phy_reset <= 1'b1;
        mc.xfer(1'b1, `MRRC_OFS_CTRL, '1);
        rd(`MRRC_OFS_CTRL, 32'h16be0000);
        mgmt_reset_event <= 1'b1;
        @(posedge mclk);
        mgmt_reset_event <= 1'b0;
        mc.xfer(1'b1, `MRRC_OFS_CTRL, '0);
        rd(`MRRC_OFS_CTRL, 32'h00010000);
        mc.xfer(1'b1, `MRRC_OFS_ROUTE, '1);
        rd(`MRRC_OFS_ROUTE, 32'hff);
        rd(16'h5900, 32'h0);
        rd(`MRRC_OFS_AUX, 32'h0);
        nvm_skip_phy_reset <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            w = {4{rnd}};
            mc.xfer(1'b1, `MRRC_OFS_CTRL, w);
            c = (w & 32'h16ba0000) | 32'h00010000;
            rd(`MRRC_OFS_CTRL, c);
            rt = rnd;
            mc.xfer(1'b1, `MRRC_OFS_ROUTE, {24'h0, rt});
            repeat (16) begin
                pv = {rnd[0], rnd, rnd ^ 8'h5a};
                pkt_in <= pv;
                sent <= 1'b1;
                qp.push_back(model(pv, c, rt));
                @(posedge mclk);
            end
            sent <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// ---- logic/mrrc_pkg.sv ----
// Types shared by the management routing block
package mrrc_pkg;
    typedef struct packed {
        logic        valid;
        logic        l2_pass;
        logic        multicast;
        logic        broadcast;
        logic        vlan_tagged;
        logic        xsum_ok;
        logic        is_arp_req;
        logic        ip_filter_cfg;
        logic [3:0]  ip_match;
        logic [7:0]  filter_hit;
    } mrrc_pkt_s;
    typedef struct packed {
        logic        to_mgmt;
        logic        to_host;
        logic        mcst_l2;
    } mrrc_route_s;
    typedef enum logic [1:0] {
        MRRC_IDLE = 2'b00,
        MRRC_RESP = 2'b01
    } mrrc_bus_e;
endpackage

// ---- logic/mrrc_regs.svh ----
// Register offsets, field positions and reset values for the management routing block
`ifndef MRRC_REGS_SVH
`define MRRC_REGS_SVH
`define MRRC_OFS_CTRL        16'h5820
`define MRRC_OFS_ROUTE       16'h5860
`define MRRC_OFS_AUX         16'h5870
`define MRRC_BIT_RST_OCC     16
`define MRRC_BIT_RX_EN       17
`define MRRC_BIT_KEEP_LINK   18
`define MRRC_BIT_RX_ALL      19
`define MRRC_BIT_MCST_PASS   20
`define MRRC_BIT_M2H_EN      21
`define MRRC_BIT_XSUM        23
`define MRRC_BIT_FIXED_TAG   25
`define MRRC_BIT_TAG_SEL     26
`define MRRC_BIT_ARP_DIS     28
`define MRRC_CTRL_WMASK      32'h16be0000
`define MRRC_CTRL_RESET      32'h10000000
`define MRRC_ROUTE_RESET     8'h00
`endif

// ---- logic/mrrc_top.sv ----
// Management receive routing control registers and packet steering
// Notes on behaviour
// - Bit 16 sets on management reset; only power-on reset clears it.
// - Bit 17 enables the wire receive path into management.
// - Bit 17 set keeps the PHY powered in power-saving states.
// - Bit 18 blocks PHY reset on PCIe resets and holds power state.
// - Writes to bit 18 ignored unless the skip-PHY-reset strap is set.
// - Power-on reset clears bit 18.
// - Bit 19 sends eligible L2-passed packets to management without a filter hit.
// - Bit 20 passes all multicast through L2; broadcast unaffected.
// - Bit 21 globally gates all per-filter host forwarding.
// - Filter n hit goes to host if route bit n and gate set.
// - Bit 23 forwards only packets with good L3 and L4 checksums.
// - Bit 25 restricts management forwarding to the selected tagging.
// - Bit 26 zero picks untagged, one picks tagged; only with bit 25.
// - Bit 28 resets to one and disables ARP IP address compare.
// - Bit 28 clear: ARP request needs IP filter set and address match.
// - Bit 28 affects management filtering only, never wake ARP.
// - Power-on reset clears the whole routing register.
`timescale 1ns/1ps
`default_nettype none
`include "mrrc_regs.svh"
module mrrc_top (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 mgmt_reset_event,
    input  wire logic                 nvm_skip_phy_reset,
    input  wire logic                 pcie_fundamental_reset_pin,
    input  wire logic                 pcie_inband_reset,
    input  wire logic                 power_saving,
    input  wire logic                 wake_arp_in,
    input  wire mrrc_pkg::mrrc_pkt_s  pkt_in,
    input  wire logic [15:0]          avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    output logic [1:0]                avs_response,
    output logic                      phy_reset,
    output logic                      phy_power_keep,
    output logic                      phy_hold_power_state,
    output logic                      wake_arp_out,
    output mrrc_pkg::mrrc_route_s     route_out
);
    import mrrc_pkg::*;

    logic [31:0] ctrl_r;
    logic [7:0]  route_r;
    logic [31:0] rdata_r;
    logic [1:0]  resp_r;
    logic        wait_r;
    mrrc_bus_e   bus_r;
    logic        phy_reset_r;
    logic        phy_keep_r;
    logic        phy_hold_r;
    logic        wake_arp_r;
    mrrc_route_s route_r2;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    wire         req       = (avs_read | avs_write) & (bus_r == MRRC_IDLE);
    wire         hit_ctrl  = avs_address == `MRRC_OFS_CTRL;
    wire         hit_route = avs_address == `MRRC_OFS_ROUTE;
    wire         hit_aux   = avs_address == `MRRC_OFS_AUX;
    wire         wr_ctrl   = req & avs_write & hit_ctrl;
    wire         wr_route  = req & avs_write & hit_route;
    wire [31:0]  bmask     = be_mask(avs_byteenable);
    // Keep-link-up bit writable only with strap set
    wire [31:0]  ctrl_wm   = `MRRC_CTRL_WMASK & ~(nvm_skip_phy_reset ? 32'h0 :
                             (32'h1 << `MRRC_BIT_KEEP_LINK)) & bmask;
    wire [31:0]  ctrl_wr   = (ctrl_r & ~ctrl_wm) | (avs_writedata & ctrl_wm);
    // Management reset flag is sticky and set wins over any write
    wire [31:0]  ctrl_nxt  = (wr_ctrl ? ctrl_wr : ctrl_r) |
                             ({31'h0, mgmt_reset_event} << `MRRC_BIT_RST_OCC);
    wire [7:0]   route_nxt = wr_route ? ((route_r & ~bmask[7:0]) |
                             (avs_writedata[7:0] & bmask[7:0])) : route_r;
    wire [31:0]  rd_mux    = hit_ctrl  ? ctrl_r :
                             hit_route ? {24'h0, route_r} :
                             hit_aux   ? {30'h0, phy_hold_r, phy_keep_r} : 32'h0;
    wire [1:0]   resp_nxt  = (hit_ctrl | hit_route | hit_aux) ? 2'b00 : 2'b10;

    wire rx_en     = ctrl_r[`MRRC_BIT_RX_EN];
    wire keep_link = ctrl_r[`MRRC_BIT_KEEP_LINK];
    wire rx_all    = ctrl_r[`MRRC_BIT_RX_ALL];
    wire mcst_pass = ctrl_r[`MRRC_BIT_MCST_PASS];
    wire m2h_en    = ctrl_r[`MRRC_BIT_M2H_EN];
    wire xsum_en   = ctrl_r[`MRRC_BIT_XSUM];
    wire fixed_tag = ctrl_r[`MRRC_BIT_FIXED_TAG];
    wire tag_sel   = ctrl_r[`MRRC_BIT_TAG_SEL];
    wire arp_dis   = ctrl_r[`MRRC_BIT_ARP_DIS];

    // Multicast passes L2 when bit 20 is set; broadcast does not
    wire l2_ok    = pkt_in.l2_pass | (mcst_pass & pkt_in.multicast & ~pkt_in.broadcast);
    wire xsum_ok  = ~xsum_en | pkt_in.xsum_ok;
    wire tag_ok   = ~fixed_tag | (tag_sel == pkt_in.vlan_tagged);
    wire arp_ok   = arp_dis | ~pkt_in.is_arp_req |
                    (pkt_in.ip_filter_cfg & (|pkt_in.ip_match));
    wire elig     = pkt_in.valid & rx_en & l2_ok & xsum_ok & tag_ok & arp_ok;
    wire flt_hit  = |pkt_in.filter_hit;
    wire to_mgmt  = elig & (rx_all | flt_hit);
    wire to_host  = elig & m2h_en & (|(pkt_in.filter_hit & route_r));
    wire pcie_rst = pcie_fundamental_reset_pin | pcie_inband_reset;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= `MRRC_CTRL_RESET;
            route_r <= `MRRC_ROUTE_RESET;
        end else begin
            ctrl_r  <= ctrl_nxt;
            route_r <= route_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_r   <= MRRC_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
            resp_r  <= 2'b00;
        end else begin
            case (bus_r)
                MRRC_IDLE: begin
                    if (req) begin
                        bus_r   <= MRRC_RESP;
                        wait_r  <= 1'b0;
                        rdata_r <= avs_read ? rd_mux : 32'h0;
                        resp_r  <= resp_nxt;
                    end
                end
                MRRC_RESP: begin
                    bus_r  <= MRRC_IDLE;
                    wait_r <= 1'b1;
                end
                default: begin
                    bus_r  <= MRRC_IDLE;
                    wait_r <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phy_reset_r <= 1'b0;
            phy_keep_r  <= 1'b0;
            phy_hold_r  <= 1'b0;
            wake_arp_r  <= 1'b0;
            route_r2    <= '0;
        end else begin
            phy_reset_r <= pcie_rst & ~keep_link;
            phy_keep_r  <= rx_en & power_saving;
            phy_hold_r  <= keep_link;
            wake_arp_r  <= wake_arp_in;
            route_r2    <= '{to_mgmt: to_mgmt, to_host: to_host & to_mgmt, mcst_l2: l2_ok};
        end
    end

    assign avs_readdata         = rdata_r;
    assign avs_waitrequest      = wait_r;
    assign avs_response         = resp_r;
    assign phy_reset            = phy_reset_r;
    assign phy_power_keep       = phy_keep_r;
    assign phy_hold_power_state = phy_hold_r;
    assign wake_arp_out         = wake_arp_r;
    assign route_out            = route_r2;
endmodule
`default_nettype wire
